// ===== hw/crl_map.svh
`ifndef CRL_MAP_SVH
`define CRL_MAP_SVH
// non-volatile array geometry
`define CRL_EE_BYTES       768
`define CRL_EE_PAGES       4'd12
`define CRL_PAGE_BYTES     64
`define CRL_ERASED         8'hFF
// fixed word locations (low byte address) and lock byte
`define CRL_ADDR_SETUP     10'h160
`define CRL_ADDR_ODRIFT    10'h164
`define CRL_ADDR_SDRIFT    10'h168
`define CRL_ADDR_LOCK      10'h16A
`define CRL_ADDR_LIMIT     10'h300
// lookup table bases and pointer limits
`define CRL_OFS_BASE       10'h000
`define CRL_SPAN_LO_BASE   10'h200
`define CRL_SPAN_HI_BASE   10'h1A0
`define CRL_PTR_LAST       8'hAF
`define CRL_PTR_SPLIT      8'h80
`define CRL_LOCK_SET       8'hFF
// refresh period
`define CRL_REFRESH_NS     1000000
`define CRL_CLK_NS         8
`define CRL_REFRESH_CYCLES (`CRL_REFRESH_NS / `CRL_CLK_NS)
// register byte offsets
`define CRL_REG_STATUS     8'h00
`define CRL_REG_TPTR       8'h04
`define CRL_REG_EEADDR     8'h08
`define CRL_REG_EEDATA     8'h0C
`define CRL_REG_ERASE      8'h10
`define CRL_REG_CAL0       8'h20
`define CRL_REG_CAL4       8'h30
// reset values and bus answers
`define CRL_CAL_RST        16'h0000
`define CRL_RESP_OKAY      2'b00
`define CRL_RESP_DECERR    2'b11
`endif

// ===== hw/crl_pkg.sv
package crl_pkg;
  // load sequencer states
  typedef enum logic [1:0] {
    crl_st_boot,
    crl_st_load,
    crl_st_run
  } crl_state_type;

  // values driven to the trim converters
  typedef struct packed {
    logic [15:0] setup_word;
    logic [15:0] offset_drift_coef;
    logic [15:0] span_drift_coef;
    logic [15:0] offset_trim_value;
    logic [15:0] span_trim_value;
  } crl_trim_type;

  // one decoded serial register write
  typedef struct packed {
    logic        valid;
    logic [2:0]  sel;
    logic [15:0] data;
  } crl_ser_wr_type;
endpackage

// ===== hw/crl_loader.sv
`timescale 1ns/1ps
`include "crl_map.svh"

// Contract
// R1: five 16-bit calibration registers, filled from array or serial port.
// R2: automatic loading only when lock byte is FF and override low.
// R3: after reset in normal mode load setup and both drift words.
// R4: after reset in normal mode load both trims from pointer tables.
// R5: each period in normal mode refresh all five registers again.
// R6: lock byte zero or override high: registers written by serial commands.
// R7: array of 768 bytes, 12 pages of 64, each page erasable.
// R8: offset table contiguous; pointer selects word at twice its value.
// R9: span table split; 00-7F upper range, 80 upward second range.
// R10: words are two bytes, low at even address, high next.
// R11: fixed words at 160, 164 and 168.
// R12: temperature digitised to 8 bits once per period into pointer.
// R13: pointers AF to FF select last entry; addresses never wrap.
// R14: host should keep oscillator trim bits; array ships erased.
// R15: zero lock byte makes the single wire port a serial input.
// R16: in calibration mode automatic refresh never overwrites serial values.
module crl_loader #(
  parameter int unsigned REFRESH_CYCLES = `CRL_REFRESH_CYCLES,
  parameter int unsigned ADDR_W         = 8
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // decoded serial writes and port mode
  input  wire crl_pkg::crl_ser_wr_type ser_wr,
  output logic                       single_wire_port_rx_en,
  // temperature converter result and override pin
  input  wire logic [7:0]            temp_code,
  input  wire logic                  lock_override,
  // trim converter outputs
  output crl_pkg::crl_trim_type      trim,
  output logic                       busy
);

  // state
  logic [7:0]              ee_mem [`CRL_EE_BYTES];
  logic [15:0]             cal [5];
  logic [7:0]              temperature_pointer;
  logic [7:0]              lock_byte;
  logic [1:0]              ovr_sync;
  logic [31:0]             tick_cnt;
  logic                    tick;
  logic [2:0]              item;
  logic [9:0]              ee_addr;
  crl_pkg::crl_state_type  state;
  logic                    calib_mode;
  logic [9:0]              ld_addr;
  logic [15:0]             ld_word;
  logic                    ld_en;
  // bus slave
  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_W-1:0]       aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    wr_go;
  logic                    wr_mapped;
  logic                    ee_wr_do;
  logic                    erase_do;
  logic [31:0]             next_rdata;
  logic                    rd_mapped;

  // clamp the pointer so it never walks past the last entry
  function automatic logic [7:0] crl_clamp(input logic [7:0] p);
    crl_clamp = (p > `CRL_PTR_LAST) ? `CRL_PTR_LAST : p;
  endfunction

  // array address of the word that feeds a register slot
  function automatic logic [9:0] crl_item_addr(input logic [2:0] k,
                                               input logic [7:0] p);
    logic [7:0] c;
    c = crl_clamp(p);
    unique case (k)
      3'h0:    crl_item_addr = `CRL_ADDR_SETUP;
      3'h1:    crl_item_addr = `CRL_ADDR_ODRIFT;
      3'h2:    crl_item_addr = `CRL_ADDR_SDRIFT;
      3'h3:    crl_item_addr = `CRL_OFS_BASE | {1'b0, c, 1'b0};
      3'h4: begin
        if (c < `CRL_PTR_SPLIT) begin
          crl_item_addr = `CRL_SPAN_LO_BASE | {2'b00, c[6:0], 1'b0};
        end else begin
          crl_item_addr = `CRL_SPAN_HI_BASE + {3'b000, c[5:0], 1'b0};
        end
      end
      default: crl_item_addr = `CRL_ADDR_SETUP;
    endcase
  endfunction

  // override pin comes from outside, two flops before use
  // no reset here: the pin must already count at the first load after
  // reset, before the lock byte read from the array can be trusted
  always_ff @(posedge aclk) begin
    ovr_sync <= {ovr_sync[0], lock_override};
  end

  // R2: mode select; any lock value other than all ones stays unlocked
  assign calib_mode = ovr_sync[1] | (lock_byte != `CRL_LOCK_SET);
  // R15: port listens for serial traffic only while unlocked
  assign single_wire_port_rx_en = calib_mode;

  // free-running period timer
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt == REFRESH_CYCLES - 1);

  // R12: sample the converter once per period, and once at boot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temperature_pointer <= 8'h00;
    end else if (state == crl_pkg::crl_st_boot || tick) begin
      temperature_pointer <= temp_code;
    end
  end

  // lock byte is re-read with every period so a reprogram takes effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_byte <= 8'h00;
    end else if (state == crl_pkg::crl_st_boot || tick) begin
      lock_byte <= ee_mem[`CRL_ADDR_LOCK];
    end
  end

  // R3: R4: R5: load sequencer, one register slot per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= crl_pkg::crl_st_boot;
      item  <= 3'h0;
    end else begin
      unique case (state)
        crl_pkg::crl_st_boot: begin
          state <= crl_pkg::crl_st_load;
          item  <= 3'h0;
        end
        crl_pkg::crl_st_load: begin
          // R16: unlocked mode aborts the load
          if (calib_mode || item == 3'h4) begin
            state <= crl_pkg::crl_st_run;
          end
          item <= item + 3'h1;
        end
        crl_pkg::crl_st_run: begin
          if (tick) begin
            state <= crl_pkg::crl_st_load;
            item  <= 3'h0;
          end
        end
      endcase
    end
  end
  assign busy = (state != crl_pkg::crl_st_run);

  // R8: R9: R11: R13: table and fixed address generation
  assign ld_addr = crl_item_addr(item, temperature_pointer);
  // R10: low byte even, high byte next
  assign ld_word = {ee_mem[ld_addr + 10'h001], ee_mem[ld_addr]};
  assign ld_en   = (state == crl_pkg::crl_st_load) && !calib_mode;

  // R1: R6: calibration registers, array load or serial write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 5; i++) begin
        cal[i] <= `CRL_CAL_RST;
      end
    end else if (ld_en) begin
      cal[item] <= ld_word;
    end else if (calib_mode && ser_wr.valid && ser_wr.sel < 3'h5) begin
      cal[ser_wr.sel] <= ser_wr.data;
    end
  end
  assign trim = {cal[0], cal[1], cal[2], cal[3], cal[4]};

  // write address and data captured separately, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_mapped     = (aw_addr == `CRL_REG_EEADDR) ||
                         (aw_addr == `CRL_REG_EEDATA) ||
                         (aw_addr == `CRL_REG_ERASE);

  // write response, one outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CRL_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `CRL_RESP_OKAY : `CRL_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // array address register for software access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_addr <= 10'h000;
    end else if (wr_go && aw_addr == `CRL_REG_EEADDR && w_strb[0]) begin
      ee_addr <= w_data[9:0];
    end
  end

  // programming is refused while locked: protects the stored coefficients
  assign ee_wr_do = wr_go && calib_mode && aw_addr == `CRL_REG_EEDATA &&
                    w_strb[0] && ee_addr < `CRL_ADDR_LIMIT;
  assign erase_do = wr_go && calib_mode && aw_addr == `CRL_REG_ERASE &&
                    w_strb[0] && w_data[3:0] < `CRL_EE_PAGES;

  // R7: byte program and single page erase; contents survive reset
  always_ff @(posedge aclk) begin
    if (erase_do) begin
      for (int i = 0; i < `CRL_PAGE_BYTES; i++) begin
        ee_mem[{w_data[3:0], 6'(i)}] <= `CRL_ERASED;
      end
    end else if (ee_wr_do) begin
      ee_mem[ee_addr] <= w_data[7:0];
    end
  end

  // read data select
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_mapped  = 1'b1;
    if (s_axi_araddr == `CRL_REG_STATUS) begin
      next_rdata = {16'h0000, lock_byte, 6'h00, busy, calib_mode};
    end else if (s_axi_araddr == `CRL_REG_TPTR) begin
      next_rdata = {24'h000000, temperature_pointer};
    end else if (s_axi_araddr == `CRL_REG_EEADDR) begin
      next_rdata = {22'h000000, ee_addr};
    end else if (s_axi_araddr == `CRL_REG_EEDATA) begin
      if (ee_addr < `CRL_ADDR_LIMIT) begin
        next_rdata = {24'h000000, ee_mem[ee_addr]};
      end
    end else if (s_axi_araddr >= `CRL_REG_CAL0 &&
                 s_axi_araddr <= `CRL_REG_CAL4 &&
                 s_axi_araddr[1:0] == 2'b00) begin
      next_rdata = {16'h0000, cal[3'(s_axi_araddr[4:2])]};
    end else if (s_axi_araddr != `CRL_REG_ERASE) begin
      rd_mapped = 1'b0;
    end
  end

  // read channel, one outstanding
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CRL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_mapped ? `CRL_RESP_OKAY : `CRL_RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  sequence s_load_start;
    state == crl_pkg::crl_st_load && item == 3'h0 && !calib_mode;
  endsequence
  sequence s_load_done;
    ##[1:6] state == crl_pkg::crl_st_run;
  endsequence

  property p_mode;
    @(posedge aclk) disable iff (!aresetn)
      calib_mode == (ovr_sync[1] || lock_byte != 8'hFF);
  endproperty
  a_mode: assert property (p_mode) // R2
    else $error("mode select wrong");

  property p_load_seq;
    @(posedge aclk) disable iff (!aresetn)
      s_load_start |-> s_load_done;
  endproperty
  a_load_seq: assert property (p_load_seq) // R3
    else $error("load did not finish");

  property p_setup_word;
    @(posedge aclk) disable iff (!aresetn)
      (ld_en && item == 3'h0) |=>
        cal[0] == {ee_mem[10'h161], ee_mem[10'h160]};
  endproperty
  a_setup_word: assert property (p_setup_word) // R11
    else $error("setup word not loaded");

  property p_refresh;
    @(posedge aclk) disable iff (!aresetn)
      (tick && state == crl_pkg::crl_st_run && !calib_mode) |=>
        state == crl_pkg::crl_st_load ##1 busy;
  endproperty
  a_refresh: assert property (p_refresh) // R5
    else $error("periodic refresh missing");

  property p_ofs_addr;
    @(posedge aclk) disable iff (!aresetn)
      (state == crl_pkg::crl_st_load && item == 3'h3) |->
        ld_addr <= 10'h15E && ld_addr[0] == 1'b0;
  endproperty
  a_ofs_addr: assert property (p_ofs_addr) // R13
    else $error("offset address out of table");

  property p_span_addr;
    @(posedge aclk) disable iff (!aresetn)
      (state == crl_pkg::crl_st_load && item == 3'h4) |->
        (temperature_pointer < 8'h80) ?
          (ld_addr == 10'h200 + {1'b0, temperature_pointer, 1'b0}) :
          (ld_addr >= 10'h1A0 && ld_addr <= 10'h1FE);
  endproperty
  a_span_addr: assert property (p_span_addr) // R9
    else $error("span address wrong");

  property p_ofs_word;
    @(posedge aclk) disable iff (!aresetn)
      (ld_en && item == 3'h3 && temperature_pointer < 8'hAF) |=>
        cal[3] == {ee_mem[{$past(temperature_pointer), 1'b1}],
                   ee_mem[{$past(temperature_pointer), 1'b0}]};
  endproperty
  a_ofs_word: assert property (p_ofs_word) // R8
    else $error("offset word wrong");

  property p_ptr;
    @(posedge aclk) disable iff (!aresetn)
      tick |=> temperature_pointer == $past(temp_code);
  endproperty
  a_ptr: assert property (p_ptr) // R12
    else $error("pointer not sampled");

  property p_ser_write;
    @(posedge aclk) disable iff (!aresetn)
      (calib_mode && ser_wr.valid && ser_wr.sel == 3'h1) |=>
        cal[1] == $past(ser_wr.data);
  endproperty
  a_ser_write: assert property (p_ser_write) // R6
    else $error("serial write lost");

  property p_ser_kept;
    @(posedge aclk) disable iff (!aresetn)
      (calib_mode && !ser_wr.valid) |=> $stable(cal[4]);
  endproperty
  a_ser_kept: assert property (p_ser_kept) // R16
    else $error("unlocked register overwritten");

  property p_locked_port;
    @(posedge aclk) disable iff (!aresetn)
      (!calib_mode && !ld_en && ser_wr.valid) |=> $stable(cal[2]);
  endproperty
  a_locked_port: assert property (p_locked_port) // R15
    else $error("serial write taken while locked");

  property p_erase;
    @(posedge aclk) disable iff (!aresetn)
      erase_do |=> ee_mem[{$past(w_data[3:0]), 6'h3F}] == 8'hFF;
  endproperty
  a_erase: assert property (p_erase) // R7
    else $error("page not erased");

endmodule

// ===== verif/crl_host_model.sv
`timescale 1ns/1ps
// stand-in for the calibration tester and the temperature converter
module crl_host_model (
  // clock
  input  wire logic               aclk,
  // stimulus toward the loader
  output crl_pkg::crl_ser_wr_type ser_wr,
  output logic [7:0]              temp_code,
  output logic                    lock_override
);
  // start unlocked so the unknown array cannot select a mode
  initial begin
    ser_wr = '0;
    temp_code = 8'h00;
    lock_override = 1'b1;
  end

  task automatic send(input logic [2:0] sel, input logic [15:0] d,
                      input int gap);
    @(posedge aclk);
    ser_wr <= '{valid: 1'b1, sel: sel, data: d};
    @(posedge aclk);
    // idle payload is inverted so a stale value never passes
    ser_wr <= '{valid: 1'b0, sel: ~sel, data: ~d};
    repeat (gap) @(posedge aclk);
  endtask

  // converter result and override pin move together
  task automatic set_temp(input logic [7:0] t, input logic ovr);
    @(posedge aclk);
    temp_code <= t;
    lock_override <= ovr;
  endtask
endmodule

// ===== verif/crl_loader_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module crl_loader_tb;
  localparam int unsigned RC = 64;
  logic                    aclk, aresetn;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata, rd;
  logic [3:0]              wstrb;
  logic                    awvalid, wvalid, bready, arvalid, rready;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp, rr;
  logic                    rx_en, busy, lock_override;
  logic [7:0]              temp_code, p;
  logic [15:0]             d [0:4];
  logic [7:0]              mem [0:767];
  logic [7:0]              pts [0:6];
  crl_pkg::crl_ser_wr_type ser_wr;
  crl_pkg::crl_trim_type   trim;
  int                      errors, n_compared;

  crl_loader #(.REFRESH_CYCLES(RC)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ser_wr(ser_wr),
    .single_wire_port_rx_en(rx_en), .temp_code(temp_code),
    .lock_override(lock_override), .trim(trim), .busy(busy));

  crl_host_model host_u (
    .aclk(aclk), .ser_wr(ser_wr), .temp_code(temp_code),
    .lock_override(lock_override));

  // free-running 125 MHz clock
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one write; address and data released independently when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 64) begin
      errors++;
      conclude();
    end
    `CHK(bresp, er)
  endtask

  task automatic rdw(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (n == 64) begin
      errors++;
      conclude();
    end
    `CHK(rr, er)
  endtask

  // array byte read back through the address and data windows
  task automatic peek(input int a);
    wr(8'h08, a, 2'b00);
    rdw(8'h0C, 2'b00);
    `CHK(rd[7:0], mem[a])
  endtask

  task automatic wait_periods(input int n);
    int k;
    repeat (n * RC + 8) @(posedge aclk);
    for (k = 0; k < 32 && busy !== 1'b0; k++) @(posedge aclk);
    if (k == 32) begin
      errors++;
      conclude();
    end
  endtask

  // expected trim outputs; low byte at the even address
  function automatic logic [15:0] wd(input int a);
    return {mem[a + 1], mem[a]};
  endfunction

  function automatic logic [79:0] exp_trim(input logic [7:0] t);
    int c;
    c = (t > 8'hAF) ? 'hAF : int'(t);
    return {wd('h160), wd('h164), wd('h168), wd(2 * c),
            (t < 8'h80) ? wd('h200 + 2 * int'(t)) : wd('h1A0 + 2 * (c - 'h80))};
  endfunction

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    errors = 0;
    n_compared = 0;
    void'($urandom(32'h5F44D94F));
    pts = '{8'h00, 8'h7F, 8'h80, 8'hAF, 8'hB0, 8'hFF, 8'h00};
    pts[6] = 8'($urandom);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(trim, 80'h0)
    `CHK(rx_en, 1'b1)
    rdw(8'h40, 2'b11);
    `CHK(rd, 32'h0)
    wr(8'h20, 32'h1234, 2'b11);
    $display("test reset and decode done");

    for (int i = 0; i < 5; i++) begin
      d[i] = 16'($urandom);
      host_u.send(3'(i), d[i], $urandom_range(0, 3));
    end
    host_u.send(3'h5, 16'hDEAD, 0);
    wait_periods(2);
    for (int i = 0; i < 5; i++) begin
      rdw(8'h20 + 8'(4 * i), 2'b00);
      `CHK(rd[15:0], d[i])
      `CHK(trim[79 - 16 * i -: 16], d[i])
    end
    $display("test serial writes done");

    for (int pg = 0; pg < 12; pg++) wr(8'h10, pg, 2'b00);
    foreach (mem[i]) mem[i] = 8'hFF;
    peek($urandom_range(0, 767));
    for (int a = 0; a < 768; a++) begin
      mem[a] = 8'($urandom);
      if (a == 'h161) mem[a] = mem[a] | 8'hE0;
      if (a == 'h16A) mem[a] = 8'hFF;
      wr(8'h08, a, 2'b00);
      wr(8'h0C, {24'h0, mem[a]}, 2'b00);
    end
    wr(8'h10, 32'hC, 2'b00);
    for (int i = 0; i < 4; i++) peek(64 * $urandom_range(0, 11));
    $display("test array program done");

    foreach (pts[i]) begin
      p = pts[i];
      host_u.set_temp(p, 1'b0);
      wait_periods(3);
      `CHK(trim, exp_trim(p))
      rdw(8'h04, 2'b00);
      `CHK(rd[7:0], p)
    end
    rdw(8'h00, 2'b00);
    `CHK(rd, 32'h0000FF00)
    `CHK(rx_en, 1'b0)
    host_u.send(3'h3, ~wd(2 * int'(8'hAF)), 0);
    repeat (4) @(posedge aclk);
    `CHK(trim, exp_trim(p))
    $display("test locked refresh done");

    host_u.set_temp(p, 1'b1);
    repeat (4) @(posedge aclk);
    `CHK(rx_en, 1'b1)
    d[1] = ~wd('h164);
    host_u.send(3'h1, d[1], 0);
    wait_periods(2);
    `CHK(trim.offset_drift_coef, d[1])
    `CHK(trim.setup_word, wd('h160))
    $display("test override done");
    conclude();
  end
endmodule
